// ==== pkg/ism_cfg.svh ====
`ifndef ISM_CFG_SVH
`define ISM_CFG_SVH

// Register offsets on the control port
`define ISM_FLAGS_ADDR    8'h7F
`define ISM_MASKS_ADDR    8'h80

// Widths
`define ISM_NSRC          10
`define ISM_AW            8
`define ISM_DW            16

// Flag and mask positions, shared by both registers; the summary bit is in the status register only
`define ISM_PIN4_BIT      9
`define ISM_SEQ_BIT       8
`define ISM_PIN3_BIT      7
`define ISM_PIN2_BIT      6
`define ISM_PIN1_BIT      5
`define ISM_IN8_BIT       4
`define ISM_IN7_BIT       3
`define ISM_LOCK_BIT      2
`define ISM_SHORT_BIT     1
`define ISM_DETECT_BIT    0
`define ISM_SUMMARY_BIT   10

// Reset values
`define ISM_FLAG_RST      10'h000
`define ISM_MASK_RST      10'h3FF
`define ISM_SRC_RST       10'h000
`define ISM_DATA_RST      16'h0000

`endif

// ==== pkg/ism_pkg.sv ====
`include "ism_cfg.svh"

package ism_pkg;

    typedef logic [`ISM_AW-1:0]   ism_addr_t;
    typedef logic [`ISM_DW-1:0]   ism_data_t;
    typedef logic [`ISM_NSRC-1:0] ism_vec_t;

    // Mask register layout, most significant field first
    typedef struct packed {
        logic pin4_event_mask;
        logic sequencer_event_mask;
        logic pin3_event_mask;
        logic pin2_event_mask;
        logic pin1_event_mask;
        logic input8_event_mask;
        logic input7_event_mask;
        logic lock_event_mask;
        logic bias_short_event_mask;
        logic bias_detect_event_mask;
    } ism_masks_s;

    // State of the top module
    typedef struct packed {
        ism_vec_t   src_prev;
        ism_masks_s masks;
        logic       irq;
        ism_data_t  rdata;
    } ism_top_s;

    // State of the flag bank
    typedef struct packed {
        ism_vec_t flags;
    } ism_bank_s;

endpackage : ism_pkg

// ==== pkg/ism_flag_if.sv ====
`timescale 1ns/1ns
`include "ism_cfg.svh"

// Set and clear requests toward the flag bank, flags back
interface ism_flag_if;
    logic [`ISM_NSRC-1:0] set_vec;
    logic [`ISM_NSRC-1:0] clr_vec;
    logic [`ISM_NSRC-1:0] flags;
    modport ctrl (output set_vec, output clr_vec, input flags);
    modport bank (input set_vec, input clr_vec, output flags);
endinterface : ism_flag_if

// ==== verilog/ism_flag_bank.sv ====
`timescale 1ns/1ns
`include "ism_cfg.svh"

module ism_flag_bank (
    input  wire logic clk,
    input  wire logic rst_n,
    ism_flag_if.bank  fl
);
    import ism_pkg::*;

    ism_bank_s bank_ff;
    ism_bank_s nxt_bank;

    ////////////////////////////////////////////////////////////////
    // Latching flags; a new event outranks a clear in the same cycle
    always_comb begin
        nxt_bank       = bank_ff;
        nxt_bank.flags = fl.set_vec | (bank_ff.flags & ~fl.clr_vec);
    end

    // Flags come out of reset cleared
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bank_ff <= '{flags: `ISM_FLAG_RST};
        end else begin
            bank_ff <= nxt_bank;
        end
    end

    assign fl.flags = bank_ff.flags;

endmodule : ism_flag_bank

// ==== verilog/ism_top.sv ====
// Added by the designer: strobed register access.
`timescale 1ns/1ns
`include "ism_cfg.svh"

module ism_top (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire ism_pkg::ism_addr_t reg_addr,
    input  wire ism_pkg::ism_data_t reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output      ism_pkg::ism_data_t reg_rdata,
    input  wire logic              pin4_in,
    input  wire logic              sequencer_busy_in,
    input  wire logic              pin3_in,
    input  wire logic              pin2_in,
    input  wire logic              pin1_in,
    input  wire logic              input8_in,
    input  wire logic              input7_in,
    input  wire logic              lock_in,
    input  wire logic              bias_short_in,
    input  wire logic              bias_detect_in,
    output      logic              irq
);
    import ism_pkg::*;

    ////////////////////////////////////////////////////////////////
    // Declarations
    ism_top_s   state_ff;
    ism_top_s   nxt_state;
    ism_vec_t   src_vec;
    ism_vec_t   edge_vec;
    ism_vec_t   clr_vec;
    ism_vec_t   flag_vec;
    ism_vec_t   mask_vec;
    ism_vec_t   live_vec;
    logic       flags_hit;
    logic       masks_hit;
    logic       flags_wr;
    logic       masks_wr;
    logic       summary;
    logic       irq_next;

    ism_flag_if fl ();

    ////////////////////////////////////////////////////////////////
    // Source collection
    // Each condition lands at the bit that its flag and mask share,
    // so status and mask registers can be read side by side.
    always_comb begin
        src_vec                  = '0;
        src_vec[`ISM_PIN4_BIT]   = pin4_in;
        src_vec[`ISM_SEQ_BIT]    = sequencer_busy_in;
        src_vec[`ISM_PIN3_BIT]   = pin3_in;
        src_vec[`ISM_PIN2_BIT]   = pin2_in;
        src_vec[`ISM_PIN1_BIT]   = pin1_in;
        src_vec[`ISM_IN8_BIT]    = input8_in;
        src_vec[`ISM_IN7_BIT]    = input7_in;
        src_vec[`ISM_LOCK_BIT]   = lock_in;
        src_vec[`ISM_SHORT_BIT]  = bias_short_in;
        src_vec[`ISM_DETECT_BIT] = bias_detect_in;
    end

    // Rising edges are the events. A condition that stays high does not
    // re-arm its flag once software has cleared it; it must drop first.
    assign edge_vec = src_vec & ~state_ff.src_prev;

    ////////////////////////////////////////////////////////////////
    // Register decode
    assign flags_hit = (reg_addr == `ISM_FLAGS_ADDR);
    assign masks_hit = (reg_addr == `ISM_MASKS_ADDR);
    assign flags_wr  = reg_wr & flags_hit;
    assign masks_wr  = reg_wr & masks_hit;

    // Write-one-to-clear; the summary bit is read-only and ignores writes
    assign clr_vec = flags_wr ? reg_wdata[`ISM_NSRC-1:0] : '0;

    ////////////////////////////////////////////////////////////////
    // Flag bank
    assign fl.set_vec = edge_vec;
    assign fl.clr_vec = clr_vec;
    assign flag_vec   = fl.flags;

    ism_flag_bank u_flag_bank (
        .clk   (clk),
        .rst_n (rst_n),
        .fl    (fl)
    );

    ////////////////////////////////////////////////////////////////
    // Summary and interrupt terms
    // Masks only gate the output; flags below them keep latching.
    assign mask_vec = state_ff.masks;
    assign live_vec = flag_vec & ~mask_vec;
    assign summary  = |flag_vec;
    assign irq_next = |live_vec;

    ////////////////////////////////////////////////////////////////
    // Next state
    // Read data stand for one cycle only and are zero otherwise, which
    // keeps a stale word from being mistaken for a fresh answer.
    always_comb begin
        nxt_state          = state_ff;
        nxt_state.src_prev = src_vec;
        nxt_state.irq      = irq_next;
        nxt_state.rdata    = '0;
        if (masks_wr) begin
            nxt_state.masks = ism_masks_s'(reg_wdata[`ISM_NSRC-1:0]);
        end
        if (reg_rd) begin
            if (flags_hit) begin
                // Sequencer bit is passed as held; meaning is software's call
                nxt_state.rdata = ism_data_t'({summary, flag_vec});
            end else if (masks_hit) begin
                nxt_state.rdata = ism_data_t'(mask_vec);
            end else begin
                nxt_state.rdata = '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= '{src_prev: `ISM_SRC_RST,
                          masks:    `ISM_MASK_RST,
                          irq:      1'b0,
                          rdata:    `ISM_DATA_RST};
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Outputs straight from flops; irq trails the flags by one cycle
    assign irq       = state_ff.irq;
    assign reg_rdata = state_ff.rdata;

    ////////////////////////////////////////////////////////////////
    // Per-source checks
    genvar i;
    generate
        for (i = 0; i < `ISM_NSRC; i++) begin : g_chk
            // An edge is latched at the next edge of the clock
            a_edge_sets_flag: assert property (
                @(posedge clk) disable iff (!rst_n)
                edge_vec[i] |=> flag_vec[i])
            else $error("event edge did not set its flag");

            // A one written to a set flag clears it
            a_write_one_clears: assert property (
                @(posedge clk) disable iff (!rst_n)
                (flags_wr && reg_wdata[i] && !edge_vec[i]) |=> !flag_vec[i])
            else $error("write of one did not clear flag");

            // A held flag survives anything but a one written to it
            a_flag_stays_latched: assert property (
                @(posedge clk) disable iff (!rst_n)
                (flag_vec[i] && !(flags_wr && reg_wdata[i])) |=> flag_vec[i])
            else $error("flag dropped without a clear");

            // Clear and event together leave the flag set
            a_set_beats_clear: assert property (
                @(posedge clk) disable iff (!rst_n)
                (edge_vec[i] && flags_wr && reg_wdata[i]) |=> flag_vec[i])
            else $error("simultaneous event lost to a clear");

            // No flag appears without an event
            a_no_spurious_flag: assert property (
                @(posedge clk) disable iff (!rst_n)
                (!flag_vec[i] && !edge_vec[i]) |=> !flag_vec[i])
            else $error("flag set with no event");

            // Masked flag keeps latching; irq follows only unmasked flags
            a_masked_still_latch: assert property (
                @(posedge clk) disable iff (!rst_n)
                (edge_vec[i] && mask_vec[i] && !masks_wr) |=>
                    (flag_vec[i] && mask_vec[i])
                    ##1 (irq == $past((flag_vec & ~mask_vec) != '0)))
            else $error("masked source stopped latching");

            // An unmasked set flag raises irq one cycle later
            a_unmasked_drives: assert property (
                @(posedge clk) disable iff (!rst_n)
                (flag_vec[i] && !mask_vec[i]) |=> irq)
            else $error("unmasked flag failed to raise irq");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////
    // Whole-block checks
    // Nothing unmasked means irq drops in the next cycle
    a_mask_blocks_irq: assert property (
        @(posedge clk) disable iff (!rst_n)
        (live_vec == '0) |=> !irq)
    else $error("irq high with every live flag masked");

    // Irq stays up while any unmasked flag remains set
    a_irq_holds: assert property (
        @(posedge clk) disable iff (!rst_n)
        (irq && (live_vec != '0)) |=> irq)
    else $error("irq dropped while an unmasked flag was set");

    // Status read returns summary over the ten flags, one cycle later
    a_summary_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        (reg_rd && flags_hit) |=>
            (reg_rdata[`ISM_SUMMARY_BIT] == $past(summary))
            && (reg_rdata[`ISM_SUMMARY_BIT] == (|reg_rdata[`ISM_NSRC-1:0])))
    else $error("summary bit does not match flags");

    // Status read returns flags at their positions, upper bits zero
    a_flag_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        (reg_rd && flags_hit) |=>
            (reg_rdata[`ISM_NSRC-1:0] == $past(flag_vec))
            && (reg_rdata[`ISM_DW-1:`ISM_SUMMARY_BIT+1] == '0))
    else $error("status read returned wrong flags");

    // A mask write lands and reads back at the same positions
    a_mask_write_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        (masks_wr && !reg_rd) ##1 (reg_rd && masks_hit) |=>
            reg_rdata == ism_data_t'($past(mask_vec)))
    else $error("mask read back differs from written value");

    // Mask register takes exactly the low bits of the write
    a_mask_takes_write: assert property (
        @(posedge clk) disable iff (!rst_n)
        masks_wr |=> mask_vec == `ISM_NSRC'($past(reg_wdata)))
    else $error("mask write not stored");

    // Out of reset every source is masked and no flag is set
    a_reset_values: assert property (
        @(posedge clk) disable iff (!rst_n)
        $rose(rst_n) |-> ((mask_vec == `ISM_MASK_RST)
                          && (flag_vec == `ISM_FLAG_RST) && !irq))
    else $error("wrong values after reset");

    // Read data live for the one cycle after a read only
    a_rdata_one_cycle: assert property (
        @(posedge clk) disable iff (!rst_n)
        !reg_rd |=> reg_rdata == '0)
    else $error("read data present without a read");

    // Unmapped reads answer zero
    a_unmapped_zero: assert property (
        @(posedge clk) disable iff (!rst_n)
        (reg_rd && !flags_hit && !masks_hit) |=> reg_rdata == '0)
    else $error("unmapped read returned data");

    // Writes to the status register never touch the masks
    a_flag_write_no_mask: assert property (
        @(posedge clk) disable iff (!rst_n)
        (flags_wr && !masks_wr) |=> $stable(mask_vec))
    else $error("status write altered masks");

endmodule : ism_top

// ==== bench/ism_host.sv ====
`timescale 1ns/1ns
// Host processor model: owns the control port, one strobe per call, a write then a read strobe in wr_rd
module ism_host (
    input  wire logic               clk,
    output      ism_pkg::ism_addr_t reg_addr,
    output      ism_pkg::ism_data_t reg_wdata,
    output      logic               reg_wr,
    output      logic               reg_rd,
    input  wire ism_pkg::ism_data_t reg_rdata
);
    import ism_pkg::*;

    // Idle bus from time zero
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr    = 1'h0;
        reg_rd    = 1'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write; the extra edge keeps two strobe updates out of one time step
    task automatic wr(input ism_addr_t a, input ism_data_t d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'h1;
        @(posedge clk);
        reg_wr    <= 1'h0;
        reg_wdata <= ~d;             // Released data must not look valid
        @(posedge clk);
    endtask : wr

    // Read; data is taken at the edge that closes the answer cycle
    task automatic rd(input ism_addr_t a, output ism_data_t d);
        reg_addr <= a;
        reg_rd   <= 1'h1;
        @(posedge clk);
        reg_rd   <= 1'h0;
        reg_addr <= ~a;
        @(posedge clk);
        d = reg_rdata;
    endtask : rd

    // Write then read of one place on back-to-back strobes
    task automatic wr_rd(input ism_addr_t a, input ism_data_t wd, output ism_data_t d);
        reg_addr  <= a;
        reg_wdata <= wd;
        reg_wr    <= 1'h1;
        @(posedge clk);
        reg_wr    <= 1'h0;
        reg_rd    <= 1'h1;
        @(posedge clk);
        reg_rd    <= 1'h0;
        reg_addr  <= ~a;
        @(posedge clk);
        d = reg_rdata;
    endtask : wr_rd
endmodule : ism_host

// ==== bench/tb_interrupt_status_mask.sv ====
`timescale 1ns/1ns
`include "ism_cfg.svh"
module tb_interrupt_status_mask;
    import ism_pkg::*;

    logic      clk   = 1'h0;
    logic      rst_n = 1'h0;
    ism_addr_t reg_addr;
    ism_data_t reg_wdata;
    ism_data_t reg_rdata;
    logic      reg_wr;
    logic      reg_rd;
    logic      irq;
    ism_vec_t  src   = 10'h000;
    int        error_cnt = 0;
    int        n_checks  = 0;
    localparam ism_addr_t FA = `ISM_FLAGS_ADDR;
    localparam ism_addr_t MA = `ISM_MASKS_ADDR;

    // 50 MHz clock
    always #10 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    // Design and host model
    ism_top ism_top_i (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pin4_in(src[`ISM_PIN4_BIT]), .sequencer_busy_in(src[`ISM_SEQ_BIT]),
        .pin3_in(src[`ISM_PIN3_BIT]), .pin2_in(src[`ISM_PIN2_BIT]),
        .pin1_in(src[`ISM_PIN1_BIT]), .input8_in(src[`ISM_IN8_BIT]),
        .input7_in(src[`ISM_IN7_BIT]), .lock_in(src[`ISM_LOCK_BIT]),
        .bias_short_in(src[`ISM_SHORT_BIT]), .bias_detect_in(src[`ISM_DETECT_BIT]),
        .irq(irq)
    );
    ism_host ism_host_i (
        .clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Comparison, read-and-compare, interrupt sample off the edge
    task automatic chk(input string what, input ism_data_t seen, input ism_data_t exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic rdc(input ism_addr_t a, input ism_data_t exp, input string what);
        ism_data_t d;
        ism_host_i.rd(a, d);
        chk(what, d, exp);
    endtask : rdc

    task automatic irqc(input logic exp, input string what);
        @(negedge clk);
        chk(what, {15'h0000, irq}, {15'h0000, exp});
        @(posedge clk);
    endtask : irqc

    // Short event on one source; the line is low again before any read
    task automatic pulse(input int i);
        src[i] <= 1'h1;
        repeat (2) @(posedge clk);
        src[i] <= 1'h0;
        repeat (3) @(posedge clk);
    endtask : pulse

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset;
        rdc(FA, 16'h0000, "flags after reset");
        rdc(MA, 16'h03FF, "masks after reset");
        irqc(1'h0, "irq after reset");
    endtask : t_reset

    // Every source alone, all masked; busy drops before the read
    task automatic t_each;
        for (int i = 0; i < 10; i++) begin
            pulse(i);
            ism_host_i.wr(FA, 16'h0000);
            rdc(FA, 16'h0400 | (16'h0001 << i), "flag latched");
            irqc(1'h0, "masked flag irq");
            ism_host_i.wr(FA, 16'h0001 << i);
            rdc(FA, 16'h0000, "flag cleared");
        end
    endtask : t_each

    task automatic t_mask;
        ism_host_i.wr(MA, 16'hFFDF);
        rdc(MA, 16'h03DF, "mask readback");
        src[5] <= 1'h1;
        repeat (4) @(posedge clk);
        irqc(1'h1, "unmasked irq");
        pulse(6);
        rdc(FA, 16'h0460, "masked still latches");
        ism_host_i.wr(FA, 16'h0420);
        repeat (3) @(posedge clk);
        rdc(FA, 16'h0440, "held level no reset");
        irqc(1'h0, "irq after clear");
        src[5] <= 1'h0;
        ism_host_i.wr(MA, 16'h039F);
        irqc(1'h1, "unmask latched flag");
        pulse(5);
        ism_host_i.wr(FA, 16'h0040);
        irqc(1'h1, "one unmasked left");
        ism_host_i.wr(FA, 16'h0020);
        irqc(1'h0, "all unmasked cleared");
    endtask : t_mask

    // New event on the very edge that takes a clear of the same flag
    task automatic t_collide;
        pulse(3);
        src[3] <= 1'h1;
        ism_host_i.wr(FA, 16'h0008);
        repeat (2) @(posedge clk);
        rdc(FA, 16'h0408, "set beats clear");
        src[3] <= 1'h0;
        ism_host_i.wr(FA, 16'h0008);
        rdc(FA, 16'h0000, "clear after collide");
    endtask : t_collide

    // Unmapped place: reads zero, touches neither register
    // Then a mask write and its read on back-to-back strobes
    task automatic t_unmapped;
        ism_data_t d;
        ism_host_i.wr(8'h81, 16'hFFFF);
        rdc(8'h81, 16'h0000, "unmapped read");
        rdc(MA, 16'h039F, "masks untouched");
        ism_host_i.wr_rd(MA, 16'hFD55, d);
        chk("mask write then read", d, 16'h0155);
    endtask : t_unmapped

    ////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic stop_test;
        $display("Checks %0d, errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    // Whole sequence needs well under a thousand cycles
    initial begin
        #(20 * 3000);
        error_cnt++;
        stop_test();
    end

    // Reset for two cycles, then the scenarios
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        t_reset();
        t_each();
        t_mask();
        t_collide();
        t_unmapped();
        stop_test();
    end
endmodule : tb_interrupt_status_mask
